// >>> bench/bus_io_channel_logic_bench.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module bus_io_channel_logic_bench
  import io_channel_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic wr_stb, rd_stb, converter_fault = 1'b0;
  module_status_t mod_status = 3'h7;
  logic [NCH-1:0] ao_open_loop = 8'h00, field_supported = 8'hFF;
  logic [NCH-1:0] field_comm_ok = 8'hFF, field_in = 8'h00;
  logic [NCH-1:0] release_input = 8'h00;
  field_var_t field_var_in = '0;
  logic [NCH-1:0][VW-1:0] ao_drive;
  logic [NCH-1:0] channel_quality_flag, channel_state_out, do_drive;
  logic di_quality, converter_health_flag, output_module_quality;
  logic failsafe_active;
  int errors = 0, checks = 0, cycles = 0;
  logic [DW-1:0] v;
  bus_io_channel_logic #(.STEP_CYC(4), .SCAN_CYCLES(64), .TIMEOUT_SCANS(4))
  i_bus_io_channel_logic (
    .core_clk(core_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .mod_status(mod_status), .ao_open_loop(ao_open_loop),
    .field_supported(field_supported), .field_comm_ok(field_comm_ok),
    .field_var_in(field_var_in), .converter_fault(converter_fault),
    .field_in(field_in), .release_input(release_input),
    .ao_drive(ao_drive), .channel_quality_flag(channel_quality_flag),
    .channel_state_out(channel_state_out), .do_drive(do_drive),
    .di_quality(di_quality), .converter_health_flag(converter_health_flag),
    .output_module_quality(output_module_quality),
    .failsafe_active(failsafe_active)
  );
  ctrl_model i_ctrl_model (
    .core_clk(core_clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata)
  );
  initial forever #5 core_clk = ~core_clk;
  task automatic close_out();
    $display("Checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      $display("Error at %0t: bench timed out", $time);
      close_out();
    end
  end
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    i_ctrl_model.bus_wr(a, d);
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    i_ctrl_model.bus_rd(a, d);
  endtask
  task automatic t_reset();
    wr(8'h60, 32'hFFFF_FFFF);
    rd(8'h60, v);
    chk(v, 32'h0);
    rd(ADDR_STATUS, v);
    chk(v, 32'h0);
    $display("Reset test done");
  endtask
  task automatic t_analog();
    wr(ADDR_AO_SIG, 32'h1F4);
    wr(ADDR_AO_MIN + 8'h01, 32'h0);
    wr(ADDR_AO_MAX + 8'h01, 32'hC8);
    wr(ADDR_AO_CFG, 32'h0000_0002);
    wr(ADDR_AO_SIG + 8'h01, 32'h32);
    cyc(12);
    chk(ao_drive[0], AO_ZERO_UA + AO_SPAN_UA / 2);
    chk(ao_drive[1], AO_ZERO_UA + AO_SPAN_UA / 4);
    $display("Analog test done");
  endtask
  task automatic t_input();
    wr(ADDR_DI_CFG, 32'h0001_0406);
    wr(ADDR_SETTLE + 8'h03, 32'h2);
    @(posedge core_clk);
    field_in <= 8'h07;
    cyc(2);
    chk(channel_state_out, 8'h07);
    @(posedge core_clk);
    field_in <= 8'h08;
    cyc(2);
    chk(channel_state_out, 8'h06);
    cyc(8);
    chk(channel_state_out, 8'h0E);
    repeat (2) begin
      @(posedge core_clk);
      field_in[0] <= 1'b1;
      cyc(2);
      @(posedge core_clk);
      field_in[0] <= 1'b0;
      cyc(2);
    end
    rd(ADDR_TALLY, v);
    chk(v, 32'h3);
    rd(ADDR_DI_STATE, v);
    chk(v, 32'hE);
    chk(channel_state_out, 8'h0C);
    @(posedge core_clk);
    release_input[2] <= 1'b1;
    cyc(2);
    chk(channel_state_out, 8'h08);
    wr(ADDR_DI_CFG, 32'h0000_0406);
    rd(ADDR_TALLY, v);
    chk(v, 32'h0);
    @(posedge core_clk);
    field_in <= 8'h00;
    release_input <= 8'h00;
    $display("Input test done");
  endtask
  task automatic t_quality();
    wr(ADDR_AO_CFG, 32'h0020_0000);
    @(posedge core_clk);
    mod_status <= 3'h3;
    converter_fault <= 1'b1;
    ao_open_loop <= 8'h04;
    field_supported <= 8'hDF;
    cyc(2);
    chk(di_quality, 1'b1);
    chk(channel_quality_flag, 8'hFF);
    chk(converter_health_flag, 1'b1);
    @(posedge core_clk);
    mod_status <= 3'h7;
    converter_fault <= 1'b0;
    field_var_in <= '{valid: 1'b1, chan: 3'h5, idx: 2'h1, data: 16'h1234};
    @(posedge core_clk);
    field_var_in <= '0;
    cyc(2);
    chk(channel_quality_flag, 8'h24);
    rd(ADDR_FIELD_VAR + 8'h15, v);
    chk(v, 32'h1234);
    @(posedge core_clk);
    ao_open_loop <= 8'h00;
    field_supported <= 8'hFF;
    $display("Quality test done");
  endtask
  task automatic t_failsafe();
    wr(ADDR_AO_CFG, 32'h0000_0100);
    wr(ADDR_AO_PRESET, 32'h7530);
    wr(ADDR_DO_CFG, 32'h0000_0103);
    wr(ADDR_DO_STATE, 32'h0A);
    cyc(12);
    chk(do_drive, 8'h0A);
    chk(ao_drive[1], AO_ZERO_UA + AO_SPAN_UA / 20);
    cyc(300);
    chk(failsafe_active, 1'b1);
    chk(output_module_quality, 1'b1);
    chk(do_drive, 8'h09);
    chk(ao_drive[0], AO_PRESET_MAX_UA);
    chk(ao_drive[1], AO_ZERO_UA + AO_SPAN_UA / 20);
    wr(ADDR_DO_STATE, 32'h0A);
    cyc(2);
    chk(failsafe_active, 1'b0);
    $display("Fail-safe test done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_analog();
    t_input();
    t_quality();
    t_failsafe();
    close_out();
  end
endmodule

// >>> bench/bus_io_channel_logic_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checks for the channel logic
// ****************************************************************
module bus_io_channel_logic_checker
  import io_channel_pkg::*;
#(
  parameter int SCAN_CYCLES = 8,
  parameter int TIMEOUT_SCANS = 4
) (
  input logic core_clk,
  input logic sys_rst,
  input logic [AW-1:0] addr,
  input logic wr_stb,
  input module_status_t mod_status,
  input logic [NCH-1:0] ao_open_loop,
  input logic converter_fault,
  input logic [NCH-1:0][VW-1:0] ao_drive,
  input logic [NCH-1:0] channel_quality_flag,
  input logic [NCH-1:0] do_drive,
  input logic di_quality,
  input logic converter_health_flag,
  input logic output_module_quality,
  input logic failsafe_active
);
  localparam int FS_MIN = (TIMEOUT_SCANS - 1) * SCAN_CYCLES;
  localparam int FS_MAX = TIMEOUT_SCANS * SCAN_CYCLES + 4;
  int since;
  int calm;
  logic refresh;
  logic span_ok;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  assign refresh = wr_stb && (addr < ADDR_AO_MIN || addr == ADDR_DO_STATE);
  always_ff @(posedge core_clk) begin
    if (sys_rst || refresh) begin
      since <= 0;
    end else if (since < FS_MAX) begin
      since <= since + 1;
    end
  end
  // Rescaling takes up to 9 cycles after reset or fail-safe exit
  always_ff @(posedge core_clk) begin
    if (sys_rst || failsafe_active) begin
      calm <= 0;
    end else if (calm < 15) begin
      calm <= calm + 1;
    end
  end
  always_comb begin
    span_ok = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      if (ao_drive[i] > AO_PRESET_MAX_UA || (calm >= 10
          && (ao_drive[i] < AO_ZERO_UA || ao_drive[i] > AO_FULL_UA))) begin
        span_ok = 1'b0;
      end
    end
  end
  a_health_follows: assert property (
    converter_fault |=> converter_health_flag)
    else $error("health flag missed fault");
  a_module_bad: assert property (
    !(&mod_status) |=> di_quality && output_module_quality
      && (&channel_quality_flag))
    else $error("bad module not flagged");
  a_open_loop: assert property (
    |ao_open_loop |=>
      (channel_quality_flag & $past(ao_open_loop)) == $past(ao_open_loop))
    else $error("open loop not flagged");
  a_fs_quality: assert property (
    failsafe_active && $past(failsafe_active) |-> output_module_quality)
    else $error("fail-safe not flagged");
  a_refresh_clears: assert property (
    wr_stb && addr == ADDR_DO_STATE |-> ##2 !failsafe_active)
    else $error("refresh kept fail-safe");
  a_fs_not_early: assert property (
    $rose(failsafe_active) |-> since >= FS_MIN)
    else $error("fail-safe too early");
  a_fs_not_late: assert property (
    since == FS_MAX |-> failsafe_active)
    else $error("fail-safe too late");
  a_do_frozen: assert property (
    failsafe_active && $past(failsafe_active, 2) && !$past(wr_stb)
      && !$past(wr_stb, 2) |-> $stable(do_drive))
    else $error("outputs moved in fail-safe");
  a_ao_span: assert property (span_ok)
    else $error("drive outside span");
endmodule

bind bus_io_channel_logic bus_io_channel_logic_checker #(
  .SCAN_CYCLES(SCAN_CYCLES), .TIMEOUT_SCANS(TIMEOUT_SCANS)
) i_bus_io_channel_logic_checker (
  .core_clk(core_clk), .sys_rst(sys_rst), .addr(addr), .wr_stb(wr_stb),
  .mod_status(mod_status), .ao_open_loop(ao_open_loop),
  .converter_fault(converter_fault), .ao_drive(ao_drive),
  .channel_quality_flag(channel_quality_flag), .do_drive(do_drive),
  .di_quality(di_quality), .converter_health_flag(converter_health_flag),
  .output_module_quality(output_module_quality),
  .failsafe_active(failsafe_active)
);

// >>> bench/ctrl_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Controller side of the register bus
// ****************************************************************
module ctrl_model
  import io_channel_pkg::*;
(
  input logic core_clk,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input logic [DW-1:0] rdata
);
  initial {addr, wdata, wr_stb, rd_stb} = '0;
  task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic bus_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule

// >>> rtl/bus_io_channel_logic.sv
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Eight analog channels, each scaled onto 4-20 mA from its range.
// [R2] Without a range source a channel scales against 0.0 to 100.0.
// [R3] Quality flags rise when module absent, wrong type or silent.
// [R4] Analog quality flag rises on an open or high-impedance loop.
// [R5] With field variables enabled, quality rises on missing field support.
// [R6] Output module goes fail-safe when not refreshed in time.
// [R7] Fail-safe holds last value, or drives preset up to 25.0 mA.
// [R8] Controller must refresh output modules within the interval.
// [R9] Discrete input reports 1 while on and 0 while off.
// [R10] Settle delay 2 ms to 512 ms in 2 ms steps before acceptance.
// [R11] With zero settle delay the input follows changes directly.
// [R12] Latching holds a high input high until released.
// [R13] Release on each controller read, or on release input rising edge.
// [R14] Each input keeps a 16-bit pulse tally that wraps to zero.
// [R15] Tally rate is bounded only by the settle filter.
// [R16] Tally value is presented only while tally enable is on.
// [R17] Converter health flag goes high on converter hardware failure.
// [R18] Eight discrete outputs, each with its own fail-safe behaviour.
// [R19] Discrete output quality also rises while in fail-safe.
// [R20] Four field variables per analog channel, update off by default.
// [R21] Fail-safe timeout held as a count of scan periods.
module bus_io_channel_logic
  import io_channel_pkg::*;
#(
  parameter int STEP_CYC = SETTLE_STEP_CYC,
  parameter int SCAN_CYCLES = SCAN_CYC,
  parameter int TIMEOUT_SCANS = FS_TIMEOUT_SCANS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DW-1:0] rdata,
  input wire module_status_t mod_status,
  input wire logic [NCH-1:0] ao_open_loop,
  input wire logic [NCH-1:0] field_supported,
  input wire logic [NCH-1:0] field_comm_ok,
  input wire field_var_t field_var_in,
  input wire logic converter_fault,
  input wire logic [NCH-1:0] field_in,
  input wire logic [NCH-1:0] release_input,
  output logic [NCH-1:0][VW-1:0] ao_drive,
  output logic [NCH-1:0] channel_quality_flag,
  output logic [NCH-1:0] channel_state_out,
  output logic [NCH-1:0] do_drive,
  output logic di_quality,
  output logic converter_health_flag,
  output logic output_module_quality,
  output logic failsafe_active
);

  // ****************************************************************
  // Scaling
  // ****************************************************************
  function automatic logic [VW-1:0] scale_ua(
    input logic signed [VW-1:0] sig,
    input logic signed [VW-1:0] lo,
    input logic signed [VW-1:0] hi
  );
    logic signed [47:0] num;
    logic signed [47:0] span;
    logic signed [47:0] res;
    num = 48'(sig) - 48'(lo);
    span = 48'(hi) - 48'(lo);
    if (span <= 0) begin
      res = 48'(AO_ZERO_UA);
    end else begin
      res = 48'(AO_ZERO_UA) + (num * 48'(AO_SPAN_UA)) / span;
    end
    // Clamp keeps an out-of-range signal inside the live span
    if (res < 48'(AO_ZERO_UA)) begin
      res = 48'(AO_ZERO_UA);
    end else if (res > 48'(AO_FULL_UA)) begin
      res = 48'(AO_FULL_UA);
    end
    return res[VW-1:0];
  endfunction

  function automatic logic [VW-1:0] clamp_preset(input logic [VW-1:0] v);
    if (v > VW'(AO_PRESET_MAX_UA)) begin
      return VW'(AO_PRESET_MAX_UA);
    end
    return v;
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [NCH-1:0][VW-1:0] ao_sig_reg;
  logic [NCH-1:0][VW-1:0] ao_min_reg;
  logic [NCH-1:0][VW-1:0] ao_max_reg;
  logic [NCH-1:0][VW-1:0] ao_preset_reg;
  logic [NCH-1:0][SW-1:0] settle_delay;
  logic [NCH-1:0] scaling_source;
  logic [NCH-1:0] failsafe_select;
  logic [NCH-1:0] field_var_update_enable;
  logic [NCH-1:0] do_state_reg;
  logic [NCH-1:0] do_fs_select;
  logic [NCH-1:0] do_preset;
  logic [NCH-1:0] hold_select;
  logic [NCH-1:0] release_mode;
  logic [NCH-1:0] tally_enable;
  logic [VW-1:0] field_var_mem [0:4*NCH-1];
  logic [2:0] wsel;
  logic refresh;

  assign wsel = addr[2:0];
  assign refresh = wr_stb && ((addr & ADDR_BLOCK_MASK) == ADDR_AO_SIG
    || addr == ADDR_DO_STATE);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ao_sig_reg <= '0;
      ao_min_reg <= '0;
      ao_max_reg <= '0;
      ao_preset_reg <= '0;
      settle_delay <= '0;
    end else if (wr_stb) begin
      case (addr & ADDR_BLOCK_MASK)
        ADDR_AO_SIG: ao_sig_reg[wsel] <= wdata[VW-1:0];
        ADDR_AO_MIN: ao_min_reg[wsel] <= wdata[VW-1:0];
        ADDR_AO_MAX: ao_max_reg[wsel] <= wdata[VW-1:0];
        ADDR_AO_PRESET: ao_preset_reg[wsel] <=
          clamp_preset(wdata[VW-1:0]); // see [R7]
        ADDR_SETTLE: begin
          // Steps of 2 ms, capped at 512 ms
          if (wdata > DW'(SETTLE_MAX_STEPS)) begin
            settle_delay[wsel] <= SW'(SETTLE_MAX_STEPS); // see [R10]
          end else begin
            settle_delay[wsel] <= wdata[SW-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scaling_source <= MASK_RST;
      failsafe_select <= MASK_RST;
      field_var_update_enable <= MASK_RST; // see [R20]
      do_state_reg <= MASK_RST;
      do_fs_select <= MASK_RST;
      do_preset <= MASK_RST;
      hold_select <= MASK_RST;
      release_mode <= MASK_RST;
      tally_enable <= MASK_RST;
    end else if (wr_stb) begin
      case (addr)
        ADDR_AO_CFG: begin
          scaling_source <= wdata[CFG_F0 +: NCH];
          failsafe_select <= wdata[CFG_F1 +: NCH];
          field_var_update_enable <= wdata[CFG_F2 +: NCH];
        end
        ADDR_DO_STATE: do_state_reg <= wdata[NCH-1:0];
        ADDR_DO_CFG: begin
          do_fs_select <= wdata[CFG_F0 +: NCH];
          do_preset <= wdata[CFG_F1 +: NCH];
        end
        ADDR_DI_CFG: begin
          hold_select <= wdata[CFG_F0 +: NCH];
          release_mode <= wdata[CFG_F1 +: NCH];
          tally_enable <= wdata[CFG_F2 +: NCH];
        end
        default: ;
      endcase
    end
  end

  // Field variables only land while the channel has updates enabled
  always_ff @(posedge core_clk) begin
    if (field_var_in.valid
        && field_var_update_enable[field_var_in.chan]) begin
      field_var_mem[{field_var_in.chan, field_var_in.idx}] <=
        field_var_in.data; // see [R20]
    end
  end

  // ****************************************************************
  // Refresh watchdog
  // ****************************************************************
  logic [31:0] scan_cnt_reg;
  logic [15:0] missed_scans_reg;
  logic scan_tick;

  assign scan_tick = (scan_cnt_reg == 32'(SCAN_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (sys_rst || scan_tick) begin
      scan_cnt_reg <= '0;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 32'h1;
    end
  end

  // Writes to the analog signal registers or to the discrete output state keep the module alive; see [R8]
  always_ff @(posedge core_clk) begin
    if (sys_rst || refresh) begin
      missed_scans_reg <= '0;
      failsafe_active <= 1'b0;
    end else if (scan_tick) begin
      if (missed_scans_reg >= 16'(TIMEOUT_SCANS - 1)) begin
        failsafe_active <= 1'b1; // see [R6] [R21]
      end else begin
        missed_scans_reg <= missed_scans_reg + 16'h1;
      end
    end
  end

  // ****************************************************************
  // Analog outputs
  // ****************************************************************
  logic [2:0] ao_ptr_reg;
  logic signed [VW-1:0] lo_sel;
  logic signed [VW-1:0] hi_sel;

  // Scaled one channel per clock so a single divider serves all eight
  always_comb begin
    if (scaling_source[ao_ptr_reg]) begin
      lo_sel = ao_min_reg[ao_ptr_reg];
      hi_sel = ao_max_reg[ao_ptr_reg];
    end else begin
      lo_sel = DEF_RANGE_MIN; // see [R2]
      hi_sel = DEF_RANGE_MAX;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ao_ptr_reg <= '0;
      ao_drive <= '0;
    end else begin
      ao_ptr_reg <= ao_ptr_reg + 3'h1;
      if (!failsafe_active) begin
        ao_drive[ao_ptr_reg] <= scale_ua(ao_sig_reg[ao_ptr_reg],
          lo_sel, hi_sel); // see [R1]
      end else if (failsafe_select[ao_ptr_reg]) begin
        ao_drive[ao_ptr_reg] <= ao_preset_reg[ao_ptr_reg]; // see [R7]
      end
    end
  end

  // ****************************************************************
  // Quality
  // ****************************************************************
  logic module_bad;
  assign module_bad = !mod_status.present || !mod_status.type_ok
    || !mod_status.comm_ok;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      channel_quality_flag <= '0;
      di_quality <= 1'b0;
      converter_health_flag <= 1'b0;
      output_module_quality <= 1'b0;
    end else begin
      channel_quality_flag <= {NCH{module_bad}} // see [R3]
        | ao_open_loop // see [R4]
        | (field_var_update_enable
           & ~(field_supported & field_comm_ok)); // see [R5]
      di_quality <= module_bad; // see [R3]
      converter_health_flag <= converter_fault; // see [R17]
      output_module_quality <= module_bad || failsafe_active; // see [R19]
    end
  end

  // ****************************************************************
  // Discrete outputs
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      do_drive <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!failsafe_active) begin
          do_drive[i] <= do_state_reg[i]; // see [R18]
        end else if (do_fs_select[i]) begin
          do_drive[i] <= do_preset[i]; // see [R7] [R18]
        end
      end
    end
  end

  // ****************************************************************
  // Discrete inputs
  // ****************************************************************
  logic [31:0] step_cnt_reg;
  logic step_tick;
  logic [NCH-1:0][SW-1:0] settle_cnt_reg;
  logic [NCH-1:0] accepted_reg;
  logic [NCH-1:0] accepted_next;
  logic [NCH-1:0] latch_reg;
  logic [NCH-1:0] release_prev_reg;
  logic [NCH-1:0] release_evt;
  logic [NCH-1:0][VW-1:0] tally_reg;
  logic di_read;

  assign step_tick = (step_cnt_reg == 32'(STEP_CYC - 1));
  assign di_read = rd_stb && (addr == ADDR_DI_STATE);

  always_ff @(posedge core_clk) begin
    if (sys_rst || step_tick) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'h1;
    end
  end

  // First step of a delay may be short, since the tick runs freely
  always_comb begin
    accepted_next = accepted_reg;
    for (int i = 0; i < NCH; i++) begin
      if (field_in[i] != accepted_reg[i]) begin
        if (settle_delay[i] == '0) begin
          accepted_next[i] = field_in[i]; // see [R11]
        end else if (step_tick
            && settle_cnt_reg[i] + SW'(1) >= settle_delay[i]) begin
          accepted_next[i] = field_in[i]; // see [R10]
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      settle_cnt_reg <= '0;
      accepted_reg <= '0;
    end else begin
      accepted_reg <= accepted_next;
      for (int i = 0; i < NCH; i++) begin
        if (field_in[i] == accepted_reg[i]
            || accepted_next[i] != accepted_reg[i]) begin
          settle_cnt_reg[i] <= '0;
        end else if (step_tick) begin
          settle_cnt_reg[i] <= settle_cnt_reg[i] + SW'(1);
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (release_mode[i]) begin
        release_evt[i] = release_input[i] && !release_prev_reg[i];
      end else begin
        release_evt[i] = di_read; // see [R13]
      end
    end
  end

  // A high input during release wins and keeps the latch set
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latch_reg <= '0;
      release_prev_reg <= '0;
    end else begin
      release_prev_reg <= release_input;
      latch_reg <= accepted_reg | (latch_reg & ~release_evt); // see [R12]
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      channel_state_out[i] = hold_select[i] ? latch_reg[i]
        : accepted_reg[i]; // see [R9] [R12]
    end
  end

  // Counts accepted rising edges, so the filter sets the top rate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tally_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (accepted_next[i] && !accepted_reg[i]) begin
          tally_reg[i] <= tally_reg[i] + VW'(1); // see [R14] [R15]
        end
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [DW-1:0] rd_mux;
  logic [DW-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[ST_DI_Q] = di_quality;
    status_word[ST_CONV] = converter_health_flag;
    status_word[ST_DO_Q] = output_module_quality;
    status_word[ST_FS] = failsafe_active;
    status_word[ST_AO_Q +: NCH] = channel_quality_flag;
  end

  always_comb begin
    rd_mux = '0;
    if ((addr & ADDR_FV_MASK) == ADDR_FIELD_VAR) begin
      rd_mux = DW'(field_var_mem[addr[4:0]]);
    end else begin
      case (addr & ADDR_BLOCK_MASK)
        ADDR_AO_SIG: rd_mux = DW'(ao_sig_reg[wsel]);
        ADDR_AO_MIN: rd_mux = DW'(ao_min_reg[wsel]);
        ADDR_AO_MAX: rd_mux = DW'(ao_max_reg[wsel]);
        ADDR_AO_PRESET: rd_mux = DW'(ao_preset_reg[wsel]);
        ADDR_SETTLE: rd_mux = DW'(settle_delay[wsel]);
        ADDR_TALLY: begin
          if (tally_enable[wsel]) begin
            rd_mux = DW'(tally_reg[wsel]); // see [R16]
          end
        end
        default: begin
          case (addr)
            ADDR_AO_CFG: rd_mux = DW'({field_var_update_enable,
              failsafe_select, scaling_source});
            ADDR_DO_STATE: rd_mux = DW'(do_state_reg);
            ADDR_DO_CFG: rd_mux = DW'({do_preset, do_fs_select});
            ADDR_DI_CFG: rd_mux = DW'({tally_enable, release_mode,
              hold_select});
            ADDR_DI_STATE: rd_mux = DW'(channel_state_out);
            ADDR_STATUS: rd_mux = status_word;
            default: rd_mux = '0;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (rd_stb) begin
      rdata <= rd_mux;
    end else begin
      rdata <= '0;
    end
  end

endmodule

// >>> rtl/io_channel_pkg.sv
package io_channel_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NCH = 8;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int VW = 16;
  localparam int SW = 9;
  // ****************************************************************
  // Register indices
  // ****************************************************************
  localparam logic [AW-1:0] ADDR_AO_SIG = 8'h00;
  localparam logic [AW-1:0] ADDR_AO_MIN = 8'h08;
  localparam logic [AW-1:0] ADDR_AO_MAX = 8'h10;
  localparam logic [AW-1:0] ADDR_AO_PRESET = 8'h18;
  localparam logic [AW-1:0] ADDR_AO_CFG = 8'h20;
  localparam logic [AW-1:0] ADDR_DO_STATE = 8'h21;
  localparam logic [AW-1:0] ADDR_DO_CFG = 8'h22;
  localparam logic [AW-1:0] ADDR_DI_CFG = 8'h23;
  localparam logic [AW-1:0] ADDR_DI_STATE = 8'h24;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h25;
  localparam logic [AW-1:0] ADDR_SETTLE = 8'h28;
  localparam logic [AW-1:0] ADDR_TALLY = 8'h30;
  localparam logic [AW-1:0] ADDR_FIELD_VAR = 8'h40;
  localparam logic [AW-1:0] ADDR_FIELD_VAR_END = 8'h5F;
  localparam logic [AW-1:0] ADDR_BLOCK_MASK = 8'hF8;
  localparam logic [AW-1:0] ADDR_FV_MASK = 8'hE0;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CFG_F0 = 0;
  localparam int CFG_F1 = 8;
  localparam int CFG_F2 = 16;
  localparam int ST_DI_Q = 0;
  localparam int ST_CONV = 1;
  localparam int ST_DO_Q = 2;
  localparam int ST_FS = 3;
  localparam int ST_AO_Q = 8;
  localparam logic [NCH-1:0] MASK_RST = 8'h00;
  localparam logic [VW-1:0] VAL_RST = 16'h0000;
  // ****************************************************************
  // Analog scaling, microamps and tenths of a percent
  // ****************************************************************
  localparam logic signed [VW-1:0] DEF_RANGE_MIN = 16'sh0000;
  localparam logic signed [VW-1:0] DEF_RANGE_MAX = 16'sh03E8;
  localparam int AO_ZERO_UA = 4000;
  localparam int AO_SPAN_UA = 16000;
  localparam int AO_FULL_UA = 20000;
  localparam int AO_PRESET_MAX_UA = 25000;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_STEP_MS = 2;
  localparam int SETTLE_STEP_CYC = SETTLE_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SETTLE_MAX_STEPS = 256;
  localparam int SCAN_PERIOD_MS = 100;
  localparam int SCAN_CYC = SCAN_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FS_TIMEOUT_SCANS = 4;
  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic present;
    logic type_ok;
    logic comm_ok;
  } module_status_t;
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [1:0] idx;
    logic [VW-1:0] data;
  } field_var_t;
endpackage
